// *** src/hsl_pkg.sv ***
// shared constants and types for the host serial link
package hsl_pkg;
  typedef enum logic {
    HSL_MODE_ASYNC = 1'b0,
    HSL_MODE_SPI = 1'b1
  } hsl_mode_e;
  localparam int CLK_HZ = 10_000_000;
  // longest wait for the first downlink byte after clear-to-send
  localparam int START_LIMIT_US = 25000;
  localparam int START_LIMIT_CYC = START_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int TIMEOUT_W = 18;
  // straps are caught one cycle after the settle count reaches this value
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // clock cycles per link bit for each strap code
  localparam logic [7:0] BIT_CYC_R0 = 8'h80;
  localparam logic [7:0] BIT_CYC_R1 = 8'h40;
  localparam logic [7:0] BIT_CYC_R2 = 8'h20;
  localparam logic [7:0] BIT_CYC_R3 = 8'h10;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [3:0] SPI_LAST_BIT = 4'h8;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  function automatic logic [7:0] hsl_bit_cycles(input logic [1:0] code);
    logic [7:0] c;
    c = BIT_CYC_R0;
    unique case (code)
      2'h0: c = BIT_CYC_R0;
      2'h1: c = BIT_CYC_R1;
      2'h2: c = BIT_CYC_R2;
      2'h3: c = BIT_CYC_R3;
    endcase
    return c;
  endfunction
endpackage

// *** src/hsl_if.sv ***
// link pins between the coprocessor end and the host end
`timescale 1ns/10ps
interface hsl_if;
  logic interface_select;
  logic bit_rate_strap0;
  logic bit_rate_strap1;
  logic host_ready_n;
  logic cts_n;
  logic rts_n;
  logic rxd;
  logic txd;
  logic transfer_request_n;
  logic rw;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;

  modport dev (
    input interface_select, bit_rate_strap0, bit_rate_strap1,
    input host_ready_n, rts_n, rxd, transfer_request_n, miso,
    output cts_n, txd, rw, sclk, ss_n, mosi
  );
  modport host (
    output interface_select, bit_rate_strap0, bit_rate_strap1,
    output host_ready_n, rts_n, rxd, transfer_request_n, miso,
    input cts_n, txd, rw, sclk, ss_n, mosi
  );
endinterface

// *** src/hsl_device.sv ***
// coprocessor end of the half-duplex host serial link
// Functional notes
// - select pin low async, high spi
// - only one transfer direction at once
// - async drives cts and txd only
// - host requests only while cts high
// - assert cts when ready for host data
// - hold cts until expected bytes arrive
// - host releases request after seeing cts
// - host starts data quickly after cts
// - no uplink start while host not ready
// - unused host ready tied low
// - host drops ready during init, queueing
// - rxd host to device, txd back
// - two straps form rate code, lsb strap0
// - spi master drives rw, sclk, ss, mosi
// - host pulls request low, waits rw
// - rw low uplink mosi, high downlink miso
// - eight bits msb first, fall launch, rise sample
// - slave select resets host shift state
`timescale 1ns/10ps
module hsl_device #(
  parameter int START_TIMEOUT_CYC = hsl_pkg::START_LIMIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  hsl_if.dev link,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] dl_len,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic dl_timeout,
  output hsl_pkg::hsl_mode_e link_mode,
  output logic [1:0] bit_rate,
  output logic cfg_valid
);
  import hsl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_UP = 3'b001,
    ST_DOWN = 3'b010,
    ST_SPI_UP = 3'b011,
    ST_SPI_DOWN = 3'b100
  } hsl_dev_state_e;

  hsl_dev_state_e state;
  logic [1:0] settle;
  logic [7:0] bit_cyc;
  logic [7:0] half;
  logic cnt_end;
  logic [7:0] cnt;
  logic [3:0] bitn;
  logic [8:0] shreg;
  logic [7:0] bytes_left;
  logic rx_busy;
  logic got_first;
  logic [TIMEOUT_W-1:0] wait_cnt;

  // straps caught once, after the host end has settled its pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle <= 2'h0;
      cfg_valid <= 1'b0;
      link_mode <= HSL_MODE_ASYNC;
      bit_rate <= 2'h0;
    end else if (!cfg_valid) begin
      settle <= settle + 2'h1;
      if (settle == STRAP_SETTLE) begin
        cfg_valid <= 1'b1;
        link_mode <= link.interface_select ? HSL_MODE_SPI
                                           : HSL_MODE_ASYNC;
        bit_rate <= {link.bit_rate_strap1, link.bit_rate_strap0};
      end
    end
  end

  // bit timing derived from the latched rate code
  assign bit_cyc = hsl_bit_cycles(bit_rate);
  assign half = {1'b0, bit_cyc[7:1]};
  assign cnt_end = (cnt == bit_cyc - 8'h01);

  // one state machine serves both modes, so only one direction is ever live
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      bitn <= 4'h0;
      shreg <= 9'h000;
      bytes_left <= 8'h00;
      rx_busy <= 1'b0;
      got_first <= 1'b0;
      wait_cnt <= '0;
      link.cts_n <= 1'b1;
      link.txd <= 1'b1;
      link.rw <= 1'b0;
      link.sclk <= 1'b1;
      link.ss_n <= 1'b1;
      link.mosi <= 1'b0;
      tx_ready <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      dl_timeout <= 1'b0;
    end else begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      dl_timeout <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          cnt <= 8'h00;
          bitn <= 4'h0;
          if (cfg_valid && link_mode == HSL_MODE_ASYNC) begin
            // downlink wins over uplink when both are pending
            if (!link.rts_n && link.cts_n) begin
              link.cts_n <= 1'b0;
              bytes_left <= dl_len;
              rx_busy <= 1'b0;
              got_first <= 1'b0;
              wait_cnt <= '0;
              state <= ST_DOWN;
            end else if (tx_valid && !link.host_ready_n) begin
              link.txd <= 1'b0;
              shreg <= {1'b1, tx_data};
              tx_ready <= 1'b1;
              state <= ST_UP;
            end
          end else if (cfg_valid) begin
            if (!link.transfer_request_n) begin
              link.rw <= 1'b1;
              link.ss_n <= 1'b0;
              state <= ST_SPI_DOWN;
            end else if (tx_valid && !link.host_ready_n) begin
              link.rw <= 1'b0;
              link.ss_n <= 1'b0;
              shreg <= {1'b0, tx_data};
              tx_ready <= 1'b1;
              state <= ST_SPI_UP;
            end
          end
        end
        ST_UP: begin
          cnt <= cnt_end ? 8'h00 : cnt + 8'h01;
          if (cnt_end) begin
            if (bitn == UART_LAST_BIT) begin
              state <= ST_IDLE;
            end else begin
              link.txd <= shreg[0];
              shreg <= {1'b1, shreg[8:1]};
              bitn <= bitn + 4'h1;
            end
          end
        end
        ST_DOWN: begin
          if (bytes_left == 8'h00) begin
            link.cts_n <= 1'b1;
            state <= ST_IDLE;
          end else if (!rx_busy) begin
            if (!got_first) begin
              wait_cnt <= wait_cnt + 1'b1;
            end
            // a host silent before its first byte must not hold the link forever
            if (!got_first &&
                wait_cnt == TIMEOUT_W'(START_TIMEOUT_CYC - 1)) begin
              link.cts_n <= 1'b1;
              dl_timeout <= 1'b1;
              state <= ST_IDLE;
            end else if (!link.rxd) begin
              rx_busy <= 1'b1;
              cnt <= 8'h00;
              bitn <= 4'h0;
            end
          end else begin
            cnt <= cnt_end ? 8'h00 : cnt + 8'h01;
            if (cnt_end) begin
              bitn <= bitn + 4'h1;
            end
            if (cnt == half) begin
              if (bitn == 4'h0 && link.rxd) begin
                rx_busy <= 1'b0; // glitch, not a start bit
              end else if (bitn == UART_LAST_BIT) begin
                // released at mid stop bit so the next start edge is seen
                rx_busy <= 1'b0;
                got_first <= 1'b1;
                if (link.rxd) begin
                  rx_data <= shreg[7:0];
                  rx_valid <= 1'b1;
                  bytes_left <= bytes_left - 8'h01;
                end
              end else if (bitn != 4'h0) begin
                shreg <= {1'b0, link.rxd, shreg[7:1]};
              end
            end
          end
        end
        ST_SPI_UP, ST_SPI_DOWN: begin
          // bit 0 is a lead period with ss low and sclk idle high
          cnt <= cnt_end ? 8'h00 : cnt + 8'h01;
          if (cnt_end) begin
            if (bitn == SPI_LAST_BIT) begin
              link.ss_n <= 1'b1;
              link.sclk <= 1'b1;
              if (state == ST_SPI_DOWN) begin
                rx_data <= shreg[7:0];
                rx_valid <= 1'b1;
              end
              state <= ST_IDLE;
            end else begin
              link.sclk <= 1'b0;
              bitn <= bitn + 4'h1;
              if (state == ST_SPI_UP) begin
                link.mosi <= shreg[7];
                shreg <= {1'b0, shreg[6:0], 1'b0};
              end
            end
          end else if (cnt == half && bitn != 4'h0) begin
            link.sclk <= 1'b1;
            if (state == ST_SPI_DOWN) begin
              shreg <= {1'b0, shreg[6:0], link.miso};
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // hsl_device

// *** src/hsl_host.sv ***
// host end of the half-duplex host serial link
`timescale 1ns/10ps
module hsl_host (
  input wire logic clk,
  input wire logic rst_n,
  hsl_if.host link,
  input hsl_pkg::hsl_mode_e mode_cfg,
  input wire logic [1:0] rate_cfg,
  input wire logic ul_accept,
  output logic [7:0] ul_data,
  output logic ul_valid,
  input wire logic [7:0] dl_data,
  input wire logic dl_valid,
  output logic dl_ready
);
  import hsl_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RTS = 2'b01,
    H_SEND = 2'b10,
    H_SPI = 2'b11
  } hsl_host_state_e;

  hsl_host_state_e state;
  logic [7:0] bit_cyc;
  logic [7:0] half;
  logic [7:0] tcnt;
  logic [3:0] tbit;
  logic [8:0] tsh;
  logic tbusy;
  logic [7:0] rcnt;
  logic [3:0] rbit;
  logic [7:0] rsh;
  logic rbusy;
  logic sclk_q;
  logic ss_q;
  logic async_mode;

  assign bit_cyc = hsl_bit_cycles(rate_cfg);
  assign half = {1'b0, bit_cyc[7:1]};
  assign async_mode = (link.interface_select == HSL_MODE_ASYNC);

  // straps and host ready; ready stays low-active only when user accepts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.interface_select <= 1'b0;
      link.bit_rate_strap0 <= 1'b0;
      link.bit_rate_strap1 <= 1'b0;
      link.host_ready_n <= 1'b1;
      sclk_q <= 1'b1;
      ss_q <= 1'b1;
    end else begin
      link.interface_select <= mode_cfg;
      link.bit_rate_strap0 <= rate_cfg[0];
      link.bit_rate_strap1 <= rate_cfg[1];
      link.host_ready_n <= !ul_accept || ul_valid;
      sclk_q <= link.sclk;
      ss_q <= link.ss_n;
    end
  end

  // downlink request handshake and byte sending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= H_IDLE;
      link.rts_n <= 1'b1;
      link.rxd <= 1'b1;
      link.transfer_request_n <= 1'b1;
      link.miso <= 1'b0;
      tcnt <= 8'h00;
      tbit <= 4'h0;
      tsh <= 9'h000;
      tbusy <= 1'b0;
      dl_ready <= 1'b0;
    end else begin
      dl_ready <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (dl_valid && async_mode && link.cts_n && !rbusy) begin
            link.rts_n <= 1'b0;
            state <= H_RTS;
          end else if (dl_valid && !async_mode && link.ss_n) begin
            link.transfer_request_n <= 1'b0;
            tsh <= {1'b0, dl_data};
            tbit <= 4'h0;
            dl_ready <= 1'b1;
            state <= H_SPI;
          end
        end
        H_RTS: begin
          if (!link.cts_n) begin
            link.rts_n <= 1'b1;
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (!tbusy) begin
            if (link.cts_n) begin
              state <= H_IDLE;
            end else if (dl_valid) begin
              link.rxd <= 1'b0;
              tsh <= {1'b1, dl_data};
              tcnt <= 8'h00;
              tbit <= 4'h0;
              tbusy <= 1'b1;
              dl_ready <= 1'b1;
            end
          end else begin
            tcnt <= (tcnt == bit_cyc - 8'h01) ? 8'h00 : tcnt + 8'h01;
            if (tcnt == bit_cyc - 8'h01) begin
              if (tbit == UART_LAST_BIT) begin
                tbusy <= 1'b0;
              end else begin
                link.rxd <= tsh[0];
                tsh <= {1'b1, tsh[8:1]};
                tbit <= tbit + 4'h1;
              end
            end
          end
        end
        H_SPI: begin
          // a new select edge with rw high means the request was taken
          if (ss_q && !link.ss_n && link.rw) begin
            link.transfer_request_n <= 1'b1;
            tbit <= 4'h0;
          end else if (!link.ss_n && link.rw && link.transfer_request_n &&
                       !link.sclk && sclk_q) begin
            link.miso <= tsh[7];
            tsh <= {1'b0, tsh[6:0], 1'b0};
            tbit <= tbit + 4'h1;
          end
          if (link.transfer_request_n && link.ss_n && !ss_q) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // uplink receive on txd or mosi
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcnt <= 8'h00;
      rbit <= 4'h0;
      rsh <= SHIFT_RESET;
      rbusy <= 1'b0;
      ul_data <= 8'h00;
      ul_valid <= 1'b0;
    end else begin
      ul_valid <= 1'b0;
      if (!async_mode) begin
        if (link.ss_n) begin
          rbit <= 4'h0;
        end else if (!link.rw && link.sclk && !sclk_q) begin
          rsh <= {rsh[6:0], link.mosi};
          rbit <= rbit + 4'h1;
          if (rbit == BYTE_LAST_BIT) begin
            ul_data <= {rsh[6:0], link.mosi};
            ul_valid <= 1'b1;
          end
        end
      end else if (!rbusy) begin
        rcnt <= 8'h00;
        rbit <= 4'h0;
        rbusy <= !link.txd;
      end else begin
        rcnt <= (rcnt == bit_cyc - 8'h01) ? 8'h00 : rcnt + 8'h01;
        if (rcnt == bit_cyc - 8'h01) begin
          rbit <= rbit + 4'h1;
        end
        if (rcnt == half) begin
          if (rbit == 4'h0 && link.txd) begin
            rbusy <= 1'b0;
          end else if (rbit == UART_LAST_BIT) begin
            rbusy <= 1'b0;
            ul_data <= rsh;
            ul_valid <= link.txd;
          end else if (rbit != 4'h0) begin
            rsh <= {link.txd, rsh[7:1]};
          end
        end
      end
    end
  end
endmodule // hsl_host

// *** dv/hsl_assertions.sv ***
// concurrent checks on the pins of the host serial link
`timescale 1ns/10ps
module hsl_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic bit_rate_strap0,
  input wire logic bit_rate_strap1,
  input wire logic host_ready_n,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic rxd,
  input wire logic txd,
  input wire logic rw,
  input wire logic sclk,
  input wire logic ss_n
);
  logic [3:0] falls;
  logic [11:0] busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_grant;
    $fell(cts_n);
  endsequence
  sequence s_start;
    ##[1:4] !rxd;
  endsequence
  // launch edges inside one select window
  always_ff @(posedge clk) begin
    if (!rst_n || ss_n) begin
      falls <= 4'h0;
    end else if ($fell(sclk)) begin
      falls <= falls + 4'h1;
    end
  end
  // covers start to mid stop bit so data falls are not taken for new frames
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 12'h0;
    end else if ($fell(txd) && busy == 12'h0) begin
      busy <= 12'(19 * (64 >> {bit_rate_strap1, bit_rate_strap0}));
    end else if (busy != 12'h0) begin
      busy <= busy - 12'h1;
    end
  end
  a_cts_after_rts: assert property ($fell(cts_n) |-> !$past(rts_n))
    else $error("clear to send without request");
  a_rts_cts_high: assert property ($fell(rts_n) |-> $past(cts_n))
    else $error("request while clear to send low");
  a_rts_release: assert property (s_grant |-> ##[1:2] rts_n)
    else $error("request not released");
  a_start_quick: assert property (s_grant |-> s_start)
    else $error("first start bit late");
  a_one_direction: assert property (!cts_n |-> txd)
    else $error("uplink during downlink");
  a_uplink_ready: assert property (
    $fell(txd) && busy == 12'h0 |-> !$past(host_ready_n))
    else $error("uplink start while host not ready");
  a_async_pins: assert property (!interface_select |-> ss_n && sclk)
    else $error("spi pins moved in async mode");
  a_spi_pins: assert property (interface_select |-> cts_n && txd)
    else $error("async pins moved in spi mode");
  a_rw_steady: assert property (!ss_n && !$past(ss_n) |-> $stable(rw))
    else $error("direction changed inside byte");
  a_sclk_select: assert property ($fell(sclk) |-> !ss_n)
    else $error("clock edge while deselected");
  a_byte_bits: assert property ($rose(ss_n) |-> falls == 4'h8)
    else $error("byte without eight clocks");
endmodule // hsl_assertions

// *** dv/test_host_serial_link_interface.sv ***
// self-checking bench joining both ends of the host serial link
`timescale 1ns/10ps
module test_host_serial_link_interface;
  import hsl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic [7:0] dl_len = 8'h00;
  hsl_mode_e mode_cfg = HSL_MODE_ASYNC;
  logic [1:0] rate_cfg = 2'h0;
  logic ul_accept = 1'b0;
  logic [7:0] dl_data = 8'h00;
  logic dl_valid = 1'b0;
  logic tx_ready, rx_valid, dl_timeout, cfg_valid, ul_valid, dl_ready;
  logic [7:0] rx_data, ul_data, sh;
  hsl_mode_e link_mode;
  logic [1:0] bit_rate;
  logic [8:0] w;
  logic sclk_d = 1'b1;
  logic ss_d = 1'b1;
  logic cts_d = 1'b1;
  int mismatches = 0;
  int comparisons = 0;
  int unsigned seed = 6808;
  int dl_q[$], ul_q[$], wire_q[$];
  int bc, rx_cnt, tx_cnt = 0;
  hsl_if lnk ();
  hsl_device #(.START_TIMEOUT_CYC(200)) u_hsl_device (.clk(clk),
    .rst_n(rst_n), .link(lnk), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .dl_len(dl_len), .rx_data(rx_data),
    .rx_valid(rx_valid), .dl_timeout(dl_timeout), .link_mode(link_mode),
    .bit_rate(bit_rate), .cfg_valid(cfg_valid));
  hsl_host u_hsl_host (.clk(clk), .rst_n(rst_n), .link(lnk),
    .mode_cfg(mode_cfg), .rate_cfg(rate_cfg), .ul_accept(ul_accept),
    .ul_data(ul_data), .ul_valid(ul_valid), .dl_data(dl_data),
    .dl_valid(dl_valid), .dl_ready(dl_ready));
  hsl_assertions u_hsl_assertions (.clk(clk), .rst_n(rst_n),
    .interface_select(lnk.interface_select),
    .bit_rate_strap0(lnk.bit_rate_strap0),
    .bit_rate_strap1(lnk.bit_rate_strap1),
    .host_ready_n(lnk.host_ready_n), .cts_n(lnk.cts_n), .rts_n(lnk.rts_n),
    .rxd(lnk.rxd), .txd(lnk.txd), .rw(lnk.rw), .sclk(lnk.sclk),
    .ss_n(lnk.ss_n));
  always #50 clk = ~clk;
  function automatic int unsigned xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for a handshake seen high at a rising edge
  task automatic await(ref logic s);
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (s !== 1'b1 && t < 5000);
    if (t >= 5000) check(9'h000, 9'h001);
  endtask
  task automatic downlink(input int n);
    logic [7:0] b;
    dl_len <= 8'(n);
    for (int k = 0; k < n; k++) begin
      b = 8'(xorshift());
      dl_q.push_back(b);
      dl_data <= b;
      dl_valid <= 1'b1;
      await(dl_ready);
    end
    dl_valid <= 1'b0;
    @(posedge clk);
  endtask
  // stall holds host ready off to prove the uplink waits for it
  task automatic uplink(input int n, input bit stall);
    logic [7:0] b;
    int c;
    for (int k = 0; k < n; k++) begin
      b = 8'(xorshift());
      ul_q.push_back(b);
      wire_q.push_back(b);
      // drop ready first: its registered copy needs a cycle to go high
      if (stall) begin
        ul_accept <= 1'b0;
        repeat (2) @(posedge clk);
      end
      tx_data <= b;
      tx_valid <= 1'b1;
      if (stall) begin
        c = tx_cnt;
        repeat (300) @(posedge clk);
        check(9'(tx_cnt), 9'(c));
        ul_accept <= 1'b1;
      end
      await(tx_ready);
    end
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask
  // user-side results against the byte model, spi bits off the wire
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      check(9'(rx_data), 9'(dl_q.pop_front()));
      if (mode_cfg == HSL_MODE_SPI) check(9'(lnk.rw), 9'h001);
    end
    if (ul_valid === 1'b1) check(9'(ul_data), 9'(ul_q.pop_front()));
    if (tx_ready === 1'b1) tx_cnt++;
    if (dl_timeout !== 1'b0) check(9'(dl_timeout), 9'h000);
    if (cts_d && lnk.cts_n === 1'b0) rx_cnt = 0;
    if (!cts_d && lnk.cts_n === 1'b1) begin
      check(9'(rx_cnt), 9'(dl_len));
    end
    if (!lnk.ss_n && !sclk_d && lnk.sclk && !lnk.rw) sh = {sh[6:0], lnk.mosi};
    if (!ss_d && lnk.ss_n === 1'b1 && !lnk.rw) begin
      check(9'(sh), 9'(wire_q.pop_front()));
    end
    sclk_d = lnk.sclk;
    ss_d = lnk.ss_n;
    cts_d = lnk.cts_n;
  end
  // async uplink frames decoded at mid bit, lsb first, then stop
  always @(posedge clk) begin
    if (rst_n && mode_cfg == HSL_MODE_ASYNC && lnk.txd === 1'b0) begin
      repeat (bc / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bc) @(posedge clk);
        w[i] = lnk.txd;
      end
      check(w, {1'b1, 8'(wire_q.pop_front())});
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // each pass resets into a new mode and strap rate
  initial begin
    int t;
    for (int p = 0; p < 4; p++) begin
      rst_n <= 1'b0;
      mode_cfg <= hsl_mode_e'(p[0]);
      rate_cfg <= 2'(3 - p);
      bc = 128 >> (3 - p);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // ready held asserted, as a host that leaves it tied low
      ul_accept <= 1'b1;
      await(cfg_valid);
      check(9'(link_mode), 9'(p[0]));
      check(9'(bit_rate), 9'(3 - p));
      rate_cfg <= 2'(p);
      repeat (4) @(posedge clk);
      check(9'(bit_rate), 9'(3 - p));
      rate_cfg <= 2'(3 - p);
      repeat (4) @(posedge clk);
      uplink(1, 1'b1);
      fork
        downlink(3);
        uplink(3, 1'b0);
      join
      t = 0;
      while (dl_q.size() + ul_q.size() + wire_q.size() != 0 && t < 9000) begin
        @(posedge clk);
        t++;
      end
      check(9'(t < 9000), 9'h001);
      repeat (2 * bc) @(posedge clk);
    end
    summarize();
  end
endmodule // test_host_serial_link_interface
